// ### logic/scw_regs.vh
// register map, field positions, control word numbers and reset values of the handler
`ifndef SCW_REGS_VH
`define SCW_REGS_VH

// register byte offsets
`define SCW_OFF_CTRL       8'h00
`define SCW_OFF_STATUS     8'h04
`define SCW_OFF_IRQ_STAT   8'h08
`define SCW_OFF_IRQ_MASK   8'h0c
`define SCW_OFF_CMD        8'h10
`define SCW_OFF_START_PER  8'h14
`define SCW_OFF_TARGET_PER 8'h18
`define SCW_OFF_ACCEL      8'h1c

// register indices
`define SCW_IDX_CTRL       4'h0
`define SCW_IDX_STATUS     4'h1
`define SCW_IDX_IRQ_STAT   4'h2
`define SCW_IDX_IRQ_MASK   4'h3
`define SCW_IDX_CMD        4'h4
`define SCW_IDX_START_PER  4'h5
`define SCW_IDX_TARGET_PER 4'h6
`define SCW_IDX_ACCEL      4'h7
`define SCW_IDX_NONE       4'hf

// control word numbers
`define SCW_CW_ENABLE      16'h0001
`define SCW_CW_PAUSE       16'h0002
`define SCW_CW_CONTINUE    16'h0003
`define SCW_CW_ESTOP       16'h0004
`define SCW_CW_CSTOP       16'h0005
`define SCW_CW_STEPDIR     16'h0006
`define SCW_CW_CWCCW       16'h0007

// status word bit positions
`define SCW_ST_PROF_EN     0
`define SCW_ST_NOT_PROC    1
`define SCW_ST_PAUSED      2
`define SCW_ST_Q_EMPTY     3
`define SCW_ST_MOVING      4
`define SCW_ST_CWCCW       5
`define SCW_ST_Q_FULL      6
`define SCW_ST_LEVEL_LO    8

// interrupt status / mask bit positions
`define SCW_IRQ_W          5
`define SCW_IRQ_CW_DONE    0
`define SCW_IRQ_Q_EMPTY    1
`define SCW_IRQ_ILLEGAL    2
`define SCW_IRQ_OVERFLOW   3
`define SCW_IRQ_STOP_DONE  4

// queued command fields
`define SCW_CMD_DIR        31
`define SCW_CMD_VEL        30

// reset values of the motion registers, in clock cycles per step
`define SCW_RST_START_PER  24'h00c350
`define SCW_RST_TARGET_PER 24'h0007d0
`define SCW_RST_ACCEL      24'h000064

// timing: longest control word handling time and clock period
`define SCW_CW_TIME_NS     3000000
`define SCW_CLK_NS         5

// bus responses
`define SCW_RESP_OKAY      2'b00
`define SCW_RESP_SLVERR    2'b10

`endif

// ### logic/scw_cmd_queue.v
// profile command queue with flush, first word shown on the output
`timescale 1ns/1ps
module scw_cmd_queue #(
	parameter W      = 32,
	parameter Q_LOG2 = 4
) (
	// clock and reset
	input  wire              clk_in,
	input  wire              rst_n_in,
	// control
	input  wire              flush_in,
	input  wire              push_in,
	input  wire [W-1:0]      data_in,
	input  wire              pop_in,
	// state
	output wire [W-1:0]      data_out,
	output wire              empty_out,
	output wire              full_out,
	output wire [Q_LOG2:0]   level_out
);
	localparam DEPTH = 1 << Q_LOG2;

	reg [W-1:0]    mem [0:DEPTH-1];
	reg [Q_LOG2:0] wr_ptr_reg;
	reg [Q_LOG2:0] rd_ptr_reg;

	assign level_out = wr_ptr_reg - rd_ptr_reg;
	assign empty_out = (level_out == {(Q_LOG2+1){1'b0}});
	assign full_out  = level_out[Q_LOG2];
	assign data_out  = mem[rd_ptr_reg[Q_LOG2-1:0]];

	always @(posedge clk_in) begin
		if (push_in && !full_out && !flush_in) begin
			mem[wr_ptr_reg[Q_LOG2-1:0]] <= data_in;
		end
	end

	always @(posedge clk_in) begin
		if (!rst_n_in || flush_in) begin
			wr_ptr_reg <= {(Q_LOG2+1){1'b0}};
			rd_ptr_reg <= {(Q_LOG2+1){1'b0}};
		end else begin
			if (push_in && !full_out) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop_in && !empty_out) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end
endmodule

// ### logic/scw_step_gen.v
// step rate generator with linear period ramp, controlled and immediate stop
`timescale 1ns/1ps
module scw_step_gen #(
	parameter W = 24
) (
	// clock and reset
	input  wire         clk_in,
	input  wire         rst_n_in,
	// motion control
	input  wire         run_in,
	input  wire         stop_in,
	input  wire         halt_in,
	input  wire [W-1:0] start_per_in,
	input  wire [W-1:0] target_per_in,
	input  wire [W-1:0] accel_in,
	// step timing
	output reg          tick_out,
	output wire         rest_out
);
	reg         moving_reg;
	reg [W-1:0] per_reg;
	reg [W-1:0] cnt_reg;

	wire [W-1:0] per_up   = (start_per_in - per_reg > accel_in) ? per_reg + accel_in
	                                                           : start_per_in;
	wire [W-1:0] per_down = (per_reg - target_per_in > accel_in) ? per_reg - accel_in
	                                                            : target_per_in;

	assign rest_out = ~moving_reg;

	always @(posedge clk_in) begin
		// halt drops the ramp at once, whatever the present rate
		if (!rst_n_in || halt_in) begin
			moving_reg <= 1'b0;
			tick_out   <= 1'b0;
			per_reg    <= {W{1'b0}};
			cnt_reg    <= {W{1'b0}};
		end else begin
			tick_out <= 1'b0;
			if (!moving_reg) begin
				if (run_in) begin
					moving_reg <= 1'b1;
					per_reg    <= start_per_in;
					cnt_reg    <= start_per_in;
				end
			end else if (!run_in && !stop_in) begin
				moving_reg <= 1'b0;
			end else if (cnt_reg == {W{1'b0}}) begin
				tick_out <= 1'b1;
				cnt_reg  <= per_reg;
				if (stop_in) begin
					if (per_reg >= start_per_in) begin
						moving_reg <= 1'b0;
					end else begin
						per_reg <= per_up;
					end
				end else if (per_reg > target_per_in) begin
					per_reg <= per_down;
				end
			end else begin
				cnt_reg <= cnt_reg - 1'b1;
			end
		end
	end
endmodule

// ### logic/scw_handler.v
// stepper control word handler: axi4-lite registers, command queue, step output
//
// Behaviour
// - each control word is acted on within 3 ms; not-processed flag held meanwhile.
// - profile commands enter the queue only after control word 1 enabled profiles.
// - word 2 sets pause; no further queued command starts until continue.
// - a distance command already running completes despite pause.
// - word 3 clears pause and advances to the next queued command.
// - continue during a running command aborts it and starts the next one.
// - continue with empty queue flags queue empty at once and ramps to rest.
// - word 4 stops step pulses at once, ignoring ramp, and empties the queue.
// - word 5 aborts the move, ramps down to rest, and empties the queue.
// - word 6 selects step plus direction level output; default after reset.
// - word 7 sends steps to forward or reverse output by motion direction.
// - profile-enabled (bit 0001) clears on emergency stop, stop done, illegal word, overflow.
`timescale 1ns/1ps
`include "scw_regs.vh"
module scw_handler #(
	parameter CNT_W    = 24,
	parameter Q_LOG2   = 4,
	parameter CW_DELAY = 1
) (
	// clock and reset
	input  wire        clk_sys_in,
	input  wire        rst_n_in,
	// axi4-lite write address and data
	input  wire [7:0]  s_axi_awaddr_in,
	input  wire        s_axi_awvalid_in,
	output reg         s_axi_awready_out,
	input  wire [31:0] s_axi_wdata_in,
	input  wire [3:0]  s_axi_wstrb_in,
	input  wire        s_axi_wvalid_in,
	output reg         s_axi_wready_out,
	// axi4-lite write response
	output reg  [1:0]  s_axi_bresp_out,
	output reg         s_axi_bvalid_out,
	input  wire        s_axi_bready_in,
	// axi4-lite read
	input  wire [7:0]  s_axi_araddr_in,
	input  wire        s_axi_arvalid_in,
	output reg         s_axi_arready_out,
	output reg  [31:0] s_axi_rdata_out,
	output reg  [1:0]  s_axi_rresp_out,
	output reg         s_axi_rvalid_out,
	input  wire        s_axi_rready_in,
	// stepper drive
	output reg         step_or_forward_output_out,
	output reg         direction_or_reverse_output_out,
	// interrupt
	output reg         irq_out
);
	localparam ST_IDLE = 3'b001;
	localparam ST_RUN  = 3'b010;
	localparam ST_STOP = 3'b100;

	localparam CW_MAX_CYC = `SCW_CW_TIME_NS / `SCW_CLK_NS;
	localparam CW_WAIT_I  = (CW_DELAY < CW_MAX_CYC) ? CW_DELAY : CW_MAX_CYC - 1;
	localparam [19:0] CW_WAIT = CW_WAIT_I[19:0];

	function [3:0] reg_idx;
		input [7:0] a;
		begin
			case (a)
				`SCW_OFF_CTRL:       reg_idx = `SCW_IDX_CTRL;
				`SCW_OFF_STATUS:     reg_idx = `SCW_IDX_STATUS;
				`SCW_OFF_IRQ_STAT:   reg_idx = `SCW_IDX_IRQ_STAT;
				`SCW_OFF_IRQ_MASK:   reg_idx = `SCW_IDX_IRQ_MASK;
				`SCW_OFF_CMD:        reg_idx = `SCW_IDX_CMD;
				`SCW_OFF_START_PER:  reg_idx = `SCW_IDX_START_PER;
				`SCW_OFF_TARGET_PER: reg_idx = `SCW_IDX_TARGET_PER;
				`SCW_OFF_ACCEL:      reg_idx = `SCW_IDX_ACCEL;
				default:             reg_idx = `SCW_IDX_NONE;
			endcase
		end
	endfunction

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					merge[i*8 +: 8] = nw[i*8 +: 8];
				end
			end
		end
	endfunction

	// bus write path
	reg                  aw_full_reg;
	reg  [7:0]           aw_addr_reg;
	reg                  w_full_reg;
	reg  [31:0]          w_data_reg;
	reg  [3:0]           w_strb_reg;
	// software registers
	reg  [15:0]          cw_num_reg;
	reg                  cw_pend_reg;
	reg  [19:0]          cw_cnt_reg;
	reg  [`SCW_IRQ_W-1:0] irq_stat_reg;
	reg  [`SCW_IRQ_W-1:0] irq_mask_reg;
	reg  [CNT_W-1:0]     start_per_reg;
	reg  [CNT_W-1:0]     target_per_reg;
	reg  [CNT_W-1:0]     accel_reg;
	reg                  prof_en_reg;
	reg                  pause_reg;
	reg                  cwccw_reg;
	reg  [2:0]           state_reg;
	reg                  dir_reg;
	reg                  vel_reg;
	reg  [CNT_W-1:0]     left_reg;
	reg                  ctl_stop_reg;
	reg  [31:0]          rd_word;
	reg  [31:0]          status_word;
	reg  [1:0]           wr_resp;

	wire                 q_empty;
	wire                 q_full;
	wire [Q_LOG2:0]      q_level;
	wire [31:0]          q_dout;
	wire                 gen_tick;
	wire                 gen_rest;

	wire aw_take     = s_axi_awvalid_in & s_axi_awready_out;
	wire w_take      = s_axi_wvalid_in & s_axi_wready_out;
	wire wr_fire     = aw_full_reg & w_full_reg & ~s_axi_bvalid_out;
	wire aw_full_nx  = (aw_full_reg & ~wr_fire) | aw_take;
	wire w_full_nx   = (w_full_reg & ~wr_fire) | w_take;
	wire [3:0] wr_idx = reg_idx(aw_addr_reg);
	wire ar_take     = s_axi_arvalid_in & s_axi_arready_out;
	wire rvalid_nx   = ar_take | (s_axi_rvalid_out & ~s_axi_rready_in);

	// control words: a new one is refused while the last is still pending
	wire cw_write = wr_fire & (wr_idx == `SCW_IDX_CTRL) & ~cw_pend_reg;
	wire cw_go    = cw_pend_reg & (cw_cnt_reg >= CW_WAIT);
	wire cw_en    = cw_go & (cw_num_reg == `SCW_CW_ENABLE);
	wire cw_pause = cw_go & (cw_num_reg == `SCW_CW_PAUSE);
	wire cw_cont  = cw_go & (cw_num_reg == `SCW_CW_CONTINUE);
	wire cw_estop = cw_go & (cw_num_reg == `SCW_CW_ESTOP);
	wire cw_cstop = cw_go & (cw_num_reg == `SCW_CW_CSTOP);
	wire cw_sd    = cw_go & (cw_num_reg == `SCW_CW_STEPDIR);
	wire cw_cc    = cw_go & (cw_num_reg == `SCW_CW_CWCCW);
	wire cw_bad   = cw_go & ~(cw_en|cw_pause|cw_cont|cw_estop|cw_cstop|cw_sd|cw_cc);

	wire cmd_wr   = wr_fire & (wr_idx == `SCW_IDX_CMD);
	wire q_push   = cmd_wr & prof_en_reg & ~q_full;
	wire q_ovf    = cmd_wr & prof_en_reg & q_full;
	wire q_flush  = cw_estop | cw_cstop;

	wire in_idle  = state_reg[0];
	wire in_run   = state_reg[1];
	wire in_stop  = state_reg[2];
	wire start_ok = in_idle & prof_en_reg & ~pause_reg & ~q_empty & ~q_flush;
	wire abort_nx = cw_cont & in_run & ~q_empty;
	wire q_pop    = start_ok | abort_nx;
	wire stop_end = in_stop & gen_rest;
	wire dist_end = in_run & ~vel_reg &
	        ((left_reg == {CNT_W{1'b0}}) | (gen_tick & (left_reg == {{(CNT_W-1){1'b0}}, 1'b1})));

	wire [`SCW_IRQ_W-1:0] irq_set;
	assign irq_set[`SCW_IRQ_CW_DONE]   = cw_go;
	assign irq_set[`SCW_IRQ_Q_EMPTY]   = cw_cont & q_empty;
	assign irq_set[`SCW_IRQ_ILLEGAL]   = cw_bad;
	assign irq_set[`SCW_IRQ_OVERFLOW]  = q_ovf;
	assign irq_set[`SCW_IRQ_STOP_DONE] = stop_end & ctl_stop_reg;

	wire [`SCW_IRQ_W-1:0] irq_clr = (wr_fire & (wr_idx == `SCW_IDX_IRQ_STAT)) ?
	                                w_data_reg[`SCW_IRQ_W-1:0] : {`SCW_IRQ_W{1'b0}};
	wire [CNT_W-1:0] per_old = (wr_idx == `SCW_IDX_START_PER)  ? start_per_reg :
	                           (wr_idx == `SCW_IDX_TARGET_PER) ? target_per_reg : accel_reg;
	wire [31:0] wr_mrg   = merge({{(32-CNT_W){1'b0}}, per_old}, w_data_reg, w_strb_reg);
	wire [31:0] mask_mrg = merge(32'h0, w_data_reg, w_strb_reg);

	scw_cmd_queue #(
		.W      (32),
		.Q_LOG2 (Q_LOG2)
	) u_queue (
		.clk_in    (clk_sys_in),
		.rst_n_in  (rst_n_in),
		.flush_in  (q_flush),
		.push_in   (q_push),
		.data_in   (w_data_reg),
		.pop_in    (q_pop),
		.data_out  (q_dout),
		.empty_out (q_empty),
		.full_out  (q_full),
		.level_out (q_level)
	);

	// an emergency stop halts the generator in the same cycle
	scw_step_gen #(
		.W (CNT_W)
	) u_gen (
		.clk_in        (clk_sys_in),
		.rst_n_in      (rst_n_in),
		.run_in        (in_run),
		.stop_in       (in_stop),
		.halt_in       (cw_estop),
		.start_per_in  (start_per_reg),
		.target_per_in (target_per_reg),
		.accel_in      (accel_reg),
		.tick_out      (gen_tick),
		.rest_out      (gen_rest)
	);

	always @* begin
		status_word = 32'h0;
		status_word[`SCW_ST_PROF_EN]  = prof_en_reg;
		status_word[`SCW_ST_NOT_PROC] = cw_pend_reg;
		status_word[`SCW_ST_PAUSED]   = pause_reg;
		status_word[`SCW_ST_Q_EMPTY]  = q_empty;
		status_word[`SCW_ST_MOVING]   = ~gen_rest;
		status_word[`SCW_ST_CWCCW]    = cwccw_reg;
		status_word[`SCW_ST_Q_FULL]   = q_full;
		status_word[`SCW_ST_LEVEL_LO +: Q_LOG2+1] = q_level;
	end

	always @* begin
		rd_word = 32'h0;
		case (reg_idx(s_axi_araddr_in))
			`SCW_IDX_CTRL:       rd_word[15:0] = cw_num_reg;
			`SCW_IDX_STATUS:     rd_word = status_word;
			`SCW_IDX_IRQ_STAT:   rd_word[`SCW_IRQ_W-1:0] = irq_stat_reg;
			`SCW_IDX_IRQ_MASK:   rd_word[`SCW_IRQ_W-1:0] = irq_mask_reg;
			`SCW_IDX_CMD:        rd_word[Q_LOG2:0] = q_level;
			`SCW_IDX_START_PER:  rd_word[CNT_W-1:0] = start_per_reg;
			`SCW_IDX_TARGET_PER: rd_word[CNT_W-1:0] = target_per_reg;
			`SCW_IDX_ACCEL:      rd_word[CNT_W-1:0] = accel_reg;
			default:             rd_word = 32'h0;
		endcase
	end

	// refused writes answer slverr so software sees them, except a command to a full queue, which answers okay
	always @* begin
		wr_resp = `SCW_RESP_OKAY;
		if (wr_idx == `SCW_IDX_NONE || wr_idx == `SCW_IDX_STATUS) begin
			wr_resp = `SCW_RESP_SLVERR;
		end else if (wr_idx == `SCW_IDX_CTRL && cw_pend_reg) begin
			wr_resp = `SCW_RESP_SLVERR;
		end else if (wr_idx == `SCW_IDX_CMD && !prof_en_reg) begin
			wr_resp = `SCW_RESP_SLVERR;
		end
	end

	// bus handshakes
	always @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			aw_full_reg       <= 1'b0;
			w_full_reg        <= 1'b0;
			aw_addr_reg       <= 8'h0;
			w_data_reg        <= 32'h0;
			w_strb_reg        <= 4'h0;
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out  <= 1'b0;
			s_axi_bvalid_out  <= 1'b0;
			s_axi_bresp_out   <= `SCW_RESP_OKAY;
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b0;
			s_axi_rdata_out   <= 32'h0;
			s_axi_rresp_out   <= `SCW_RESP_OKAY;
		end else begin
			aw_full_reg       <= aw_full_nx;
			w_full_reg        <= w_full_nx;
			s_axi_awready_out <= ~aw_full_nx;
			s_axi_wready_out  <= ~w_full_nx;
			if (aw_take) begin
				aw_addr_reg <= s_axi_awaddr_in;
			end
			if (w_take) begin
				w_data_reg <= s_axi_wdata_in;
				w_strb_reg <= s_axi_wstrb_in;
			end
			if (wr_fire) begin
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out  <= wr_resp;
			end else if (s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
			end
			s_axi_arready_out <= ~rvalid_nx;
			s_axi_rvalid_out  <= rvalid_nx;
			if (ar_take) begin
				s_axi_rdata_out <= rd_word;
				s_axi_rresp_out <= (reg_idx(s_axi_araddr_in) == `SCW_IDX_NONE) ?
				                   `SCW_RESP_SLVERR : `SCW_RESP_OKAY;
			end
		end
	end

	// software registers and control word intake
	always @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			cw_num_reg     <= 16'h0;
			cw_pend_reg    <= 1'b0;
			cw_cnt_reg     <= 20'h0;
			irq_stat_reg   <= {`SCW_IRQ_W{1'b0}};
			irq_mask_reg   <= {`SCW_IRQ_W{1'b0}};
			start_per_reg  <= `SCW_RST_START_PER;
			target_per_reg <= `SCW_RST_TARGET_PER;
			accel_reg      <= `SCW_RST_ACCEL;
			irq_out        <= 1'b0;
		end else begin
			if (cw_write) begin
				cw_num_reg  <= w_data_reg[15:0];
				cw_pend_reg <= 1'b1;
				cw_cnt_reg  <= 20'h0;
			end else if (cw_go) begin
				cw_pend_reg <= 1'b0;
			end else if (cw_pend_reg) begin
				cw_cnt_reg <= cw_cnt_reg + 1'b1;
			end
			if (wr_fire && wr_idx == `SCW_IDX_IRQ_MASK) begin
				irq_mask_reg <= mask_mrg[`SCW_IRQ_W-1:0];
			end
			if (wr_fire && wr_idx == `SCW_IDX_START_PER) begin
				start_per_reg <= wr_mrg[CNT_W-1:0];
			end
			if (wr_fire && wr_idx == `SCW_IDX_TARGET_PER) begin
				target_per_reg <= wr_mrg[CNT_W-1:0];
			end
			if (wr_fire && wr_idx == `SCW_IDX_ACCEL) begin
				accel_reg <= wr_mrg[CNT_W-1:0];
			end
			// a new event wins over a write-one-to-clear in the same cycle
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
			irq_out      <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// profile flags and output mode
	always @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			prof_en_reg <= 1'b0;
			pause_reg   <= 1'b0;
			cwccw_reg   <= 1'b0;
		end else begin
			if (cw_estop || cw_bad || q_ovf || (stop_end && ctl_stop_reg)) begin
				prof_en_reg <= 1'b0;
			end else if (cw_en) begin
				prof_en_reg <= 1'b1;
			end
			if (cw_pause) begin
				pause_reg <= 1'b1;
			end else if (cw_cont) begin
				pause_reg <= 1'b0;
			end
			if (cw_sd) begin
				cwccw_reg <= 1'b0;
			end else if (cw_cc) begin
				cwccw_reg <= 1'b1;
			end
		end
	end

	// command sequencer; a distance end stops without a planned ramp-down
	always @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			state_reg    <= ST_IDLE;
			dir_reg      <= 1'b0;
			vel_reg      <= 1'b0;
			left_reg     <= {CNT_W{1'b0}};
			ctl_stop_reg <= 1'b0;
		end else if (cw_estop) begin
			state_reg <= ST_IDLE;
		end else if (cw_cstop) begin
			state_reg    <= ST_STOP;
			ctl_stop_reg <= 1'b1;
		end else if (q_pop) begin
			state_reg <= ST_RUN;
			dir_reg   <= q_dout[`SCW_CMD_DIR];
			vel_reg   <= q_dout[`SCW_CMD_VEL];
			left_reg  <= q_dout[CNT_W-1:0];
		end else if (cw_cont && in_run) begin
			state_reg    <= ST_STOP;
			ctl_stop_reg <= 1'b0;
		end else begin
			case (state_reg)
				ST_RUN: begin
					if (dist_end) begin
						state_reg <= ST_IDLE;
					end else if (gen_tick && !vel_reg) begin
						left_reg <= left_reg - 1'b1;
					end
				end
				ST_STOP: begin
					if (gen_rest) begin
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// drive pins: step/direction or forward/reverse pulses, one cycle wide
	always @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			step_or_forward_output_out      <= 1'b0;
			direction_or_reverse_output_out <= 1'b0;
		end else if (cwccw_reg) begin
			step_or_forward_output_out      <= gen_tick & ~cw_estop & ~dir_reg;
			direction_or_reverse_output_out <= gen_tick & ~cw_estop & dir_reg;
		end else begin
			step_or_forward_output_out      <= gen_tick & ~cw_estop;
			direction_or_reverse_output_out <= dir_reg;
		end
	end
endmodule

// ### tb/scw_drive_model.sv
// stepper drive model: counts forward and reverse steps seen on the pulse pins
`timescale 1ns/1ps
module scw_drive_model (
	// clock and pins
	input  wire        clk_in,
	input  wire        cw_mode_in,
	input  wire        step_in,
	input  wire        rev_in,
	// step counts
	output reg  [15:0] fwd_cnt_out = 16'h0,
	output reg  [15:0] rev_cnt_out = 16'h0
);
	// counters never reset, so the bench compares totals across a whole run
	always @(posedge clk_in) begin
		if (cw_mode_in) begin
			fwd_cnt_out <= fwd_cnt_out + {15'h0, step_in};
			rev_cnt_out <= rev_cnt_out + {15'h0, rev_in};
		end else if (step_in) begin
			fwd_cnt_out <= fwd_cnt_out + {15'h0, !rev_in};
			rev_cnt_out <= rev_cnt_out + {15'h0, rev_in};
		end
	end
endmodule

// ### tb/scw_handler_props.sv
// bus and drive pin assertions for the control word handler
`timescale 1ns/1ps
module scw_handler_props (
	// clock and reset
	input logic        clk_sys_in,
	input logic        rst_n_in,
	// bus
	input logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in,
	input logic [31:0] s_axi_wdata_in, s_axi_rdata_out,
	input logic        s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out,
	input logic [1:0]  s_axi_bresp_out, s_axi_rresp_out,
	input logic        s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out,
	input logic        s_axi_rvalid_out, s_axi_rready_in,
	// drive
	input logic        step_or_forward_output_out, direction_or_reverse_output_out
);
	logic [7:0]  a_reg;
	logic [15:0] d_reg;
	logic        bv_reg, cw_reg;
	wire wa = s_axi_awvalid_in && s_axi_awready_out;
	wire ww = s_axi_wvalid_in && s_axi_wready_out;
	// first cycle of an accepted control word response
	wire bn = s_axi_bvalid_out && !bv_reg && s_axi_bresp_out == 2'b00 && a_reg == 8'h00;
	wire es = bn && d_reg == 16'h4;
	always @(posedge clk_sys_in) begin
		bv_reg <= rst_n_in && s_axi_bvalid_out;
		if (wa) a_reg <= s_axi_awaddr_in;
		if (ww) d_reg <= s_axi_wdata_in[15:0];
		if (!rst_n_in) cw_reg <= 1'b0;
		else if (bn && d_reg == 16'h7) cw_reg <= 1'b1;
		else if (bn && d_reg == 16'h6) cw_reg <= 1'b0;
	end
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	property p_b_lat; wa && ww |-> ##2 s_axi_bvalid_out; endproperty
	a_b_lat: assert property (p_b_lat) else $error("write response not on time");
	property p_aw_drop; wa |=> !s_axi_awready_out; endproperty
	a_aw_drop: assert property (p_aw_drop) else $error("awready stayed high");
	property p_b_hold;
		s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_w_err;
		$rose(s_axi_bvalid_out) && (a_reg == 8'h04 || a_reg > 8'h1c) |-> s_axi_bresp_out == 2'b10;
	endproperty
	a_w_err: assert property (p_w_err) else $error("bad write not refused");
	property p_r_lat; s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out; endproperty
	a_r_lat: assert property (p_r_lat) else $error("read data not on time");
	property p_r_err;
		s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in > 8'h1c
			|=> s_axi_rresp_out == 2'b10 && s_axi_rdata_out == 32'h0;
	endproperty
	a_r_err: assert property (p_r_err) else $error("bad read not refused");
	property p_r_hold;
		s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_ar_blk; s_axi_rvalid_out |-> !s_axi_arready_out; endproperty
	a_ar_blk: assert property (p_ar_blk) else $error("arready while read pending");
	property p_estop; es |-> ##2 (!step_or_forward_output_out) [*8]; endproperty
	a_estop: assert property (p_estop) else $error("steps after emergency stop");
	// the mode flag here runs ahead of the design, so the old mode must also hold
	property p_cw;
		cw_reg && $past(cw_reg, 4) |-> !(step_or_forward_output_out && direction_or_reverse_output_out);
	endproperty
	a_cw: assert property (p_cw) else $error("both pulse pins high");
	c_estop: cover property (es);
	c_cw: cover property (cw_reg && direction_or_reverse_output_out);
	c_err: cover property ($rose(s_axi_bvalid_out) && s_axi_bresp_out == 2'b10);
endmodule
bind scw_handler scw_handler_props u_scw_handler_props (.*);

// ### tb/tb_top.sv
// self-checking bench: register table, control words, drive pulses, interrupt
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {
		logic        w;
		logic [7:0]  a;
		logic [31:0] d;
		logic [1:0]  s;
		logic [31:0] e;
	} scw_row_t;
	logic        clk_sys_in = 1'b0, rst_n_in = 1'b0, cw_m = 1'b0;
	logic        aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
	logic [7:0]  aw_a = 8'h0, ar_a = 8'h0;
	logic [31:0] w_d = 32'h0, rs, rdat;
	logic [15:0] f0;
	int          error_cnt = 0, n_tests = 0, tn = 0;
	wire         aw_r, w_r, b_v, ar_r, r_v, stp, rev, irq;
	wire  [1:0]  b_s, r_s;
	wire  [31:0] r_d;
	wire  [15:0] fc, rc;
	scw_row_t rows [11] = '{
		'{1'b0, 8'h14, 32'h0, 2'h0, 32'h00c350}, '{1'b0, 8'h18, 32'h0, 2'h0, 32'h0007d0},
		'{1'b0, 8'h1c, 32'h0, 2'h0, 32'h000064}, '{1'b0, 8'h04, 32'h0, 2'h0, 32'h8},
		'{1'b0, 8'h20, 32'h0, 2'h2, 32'h0}, '{1'b1, 8'h04, 32'h0, 2'h2, 32'h0},
		'{1'b1, 8'h10, 32'h1, 2'h2, 32'h0}, '{1'b1, 8'h14, 32'h8, 2'h0, 32'h0},
		'{1'b1, 8'h18, 32'h4, 2'h0, 32'h0}, '{1'b1, 8'h1c, 32'h1, 2'h0, 32'h0},
		'{1'b0, 8'h14, 32'h0, 2'h0, 32'h8}};
	scw_handler u_scw_handler (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.s_axi_awaddr_in(aw_a), .s_axi_awvalid_in(aw_v), .s_axi_awready_out(aw_r),
		.s_axi_wdata_in(w_d), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(w_v),
		.s_axi_wready_out(w_r), .s_axi_bresp_out(b_s), .s_axi_bvalid_out(b_v),
		.s_axi_bready_in(b_r), .s_axi_araddr_in(ar_a), .s_axi_arvalid_in(ar_v),
		.s_axi_arready_out(ar_r), .s_axi_rdata_out(r_d), .s_axi_rresp_out(r_s),
		.s_axi_rvalid_out(r_v), .s_axi_rready_in(r_r), .step_or_forward_output_out(stp),
		.direction_or_reverse_output_out(rev), .irq_out(irq));
	scw_drive_model u_scw_drive_model (.clk_in(clk_sys_in), .cw_mode_in(cw_m),
		.step_in(stp), .rev_in(rev), .fwd_cnt_out(fc), .rev_cnt_out(rc));
	initial forever #2.5 clk_sys_in = ~clk_sys_in;
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// ready is raised late on purpose so every response is stalled for a cycle
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic ap, wp;
		@(posedge clk_sys_in);
		aw_a <= a;
		w_d <= d;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		ap = 1'b1;
		wp = 1'b1;
		while (ap || wp) begin
			@(posedge clk_sys_in);
			if (ap && aw_r) begin
				aw_v <= 1'b0;
				ap = 1'b0;
			end
			if (wp && w_r) begin
				w_v <= 1'b0;
				wp = 1'b0;
			end
		end
		repeat (2) @(posedge clk_sys_in);
		b_r <= 1'b1;
		do @(posedge clk_sys_in); while (b_v !== 1'b1);
		rs = {30'h0, b_s};
		b_r <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk_sys_in);
		ar_a <= a;
		ar_v <= 1'b1;
		do @(posedge clk_sys_in); while (ar_r !== 1'b1);
		ar_v <= 1'b0;
		@(posedge clk_sys_in);
		r_r <= 1'b1;
		do @(posedge clk_sys_in); while (r_v !== 1'b1);
		rdat = r_d;
		rs = {30'h0, r_s};
		r_r <= 1'b0;
	endtask
	task wreg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
		do rd(a); while ((rdat & m) !== v);
	endtask
	task cw(input logic [15:0] n);
		wreg(8'h04, 32'h2, 32'h0);
		wr(8'h00, {16'h0, n});
		wreg(8'h04, 32'h2, 32'h0);
	endtask
	task go(input logic [31:0] c);
		wr(8'h10, c);
		wreg(8'h04, 32'h18, 32'h08);
	endtask
	task td();
		tn++;
		$display("test %0d done", tn);
	endtask
	task tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clk_sys_in);
		error_cnt++;
		$display("Error %0t: watchdog expired", $time);
		tally_and_finish();
	end
	initial begin
		repeat (16) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].w) begin
				wr(rows[i].a, rows[i].d);
			end else begin
				rd(rows[i].a);
				chk(rdat, rows[i].e);
			end
			chk(rs, {30'h0, rows[i].s});
		end
		td();
		cw(16'h1);
		go(32'h00000005);
		go(32'h80000002);
		chk({fc, rc}, {16'h5, 16'h2});
		cw(16'h7);
		cw_m <= 1'b1;
		go(32'h80000003);
		go(32'h00000002);
		chk({fc, rc}, {16'h7, 16'h5});
		cw(16'h6);
		cw_m <= 1'b0;
		td();
		wr(8'h10, 32'h10);
		wreg(8'h04, 32'h10, 32'h10);
		cw(16'h2);
		wr(8'h10, 32'h3);
		wreg(8'h04, 32'h10, 32'h0);
		repeat (100) @(posedge clk_sys_in);
		rd(8'h04);
		chk(32'({fc, rdat[3:2]}), 32'({16'h17, 2'b01}));
		cw(16'h3);
		wreg(8'h04, 32'h18, 32'h08);
		chk(32'(fc), 32'h1a);
		wr(8'h10, 32'h40000000);
		wr(8'h10, 32'h80000002);
		wreg(8'h04, 32'h10, 32'h10);
		repeat (40) @(posedge clk_sys_in);
		cw(16'h3);
		wreg(8'h04, 32'h18, 32'h08);
		chk(32'(rc), 32'h7);
		td();
		wr(8'h08, 32'h1f);
		cw(16'h3);
		rd(8'h08);
		chk({rdat[30:0], irq}, {31'h3, 1'b0});
		wr(8'h0c, 32'h2);
		@(posedge clk_sys_in);
		chk(32'(irq), 32'h1);
		wr(8'h08, 32'h2);
		@(posedge clk_sys_in);
		chk(32'(irq), 32'h0);
		td();
		wr(8'h10, 32'h40000000);
		wreg(8'h04, 32'h10, 32'h10);
		cw(16'h4);
		f0 = fc;
		repeat (50) @(posedge clk_sys_in);
		rd(8'h04);
		chk(32'({fc - f0, rdat[4:0]}), 32'({16'h0, 5'h08}));
		cw(16'h1);
		wr(8'h10, 32'h40000000);
		wr(8'h10, 32'h5);
		wreg(8'h04, 32'h10, 32'h10);
		repeat (40) @(posedge clk_sys_in);
		cw(16'h5);
		wreg(8'h08, 32'h10, 32'h10);
		rd(8'h04);
		chk(32'(rdat[4:0]), 32'h08);
		td();
		cw(16'h1);
		cw(16'h7);
		cw(16'h9);
		rd(8'h04);
		chk(32'(rdat[5:0]), 32'h28);
		rd(8'h08);
		chk(rdat & 32'h4, 32'h4);
		cw(16'h1);
		cw(16'h2);
		repeat (17) wr(8'h10, 32'h5);
		rd(8'h04);
		chk(32'(rdat[6:0]), 32'h64);
		rst_n_in <= 1'b0;
		repeat (16) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		rd(8'h04);
		chk(rdat, 32'h08);
		td();
		tally_and_finish();
	end
endmodule
